/* rtl/gdfm_fault_manager.sv */
// Three-phase gate driver fault supervision and PWM gating
`timescale 1ns/1ps
`include "gdfm_consts.svh"

module gdfm_fault_manager #(
   parameter int unsigned LATCH_CYCLES = `GDFM_LATCH_CYCLES
) (
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       reset_in,
   // Controller pins
   input  wire logic [2:0] low_side_switch_cmd_in,
   input  wire logic [2:0] high_side_switch_cmd_in,
   input  wire logic       driver_reset_active_low_in,
   input  wire logic       report_per_phase_in,
   // Primary supply monitors, one per phase
   input  wire logic [2:0] supply_undervoltage_lockout_in,
   input  wire logic [2:0] primary_power_good_in,
   // Secondary monitors, index 2*phase for low side, +1 for high side
   input  wire logic [5:0] sec_supply_undervoltage_lockout_in,
   input  wire logic [5:0] sec_power_good_in,
   input  wire logic [5:0] desat_comparator_in,
   input  wire logic [5:0] sec_supply_present_in,
   // Gate side
   output logic      [2:0] low_side_gate_drive_out,
   output logic      [2:0] high_side_gate_drive_out,
   output logic      [5:0] soft_shutdown_out,
   output logic      [5:0] miller_clamp_out,
   output logic      [2:0] converter_enable_out,
   // Open-drain fault reports, enable low pulls the pin low
   output logic      [2:0] bottom_fault_report_oe_n_out,
   output logic      [2:0] top_fault_report_oe_n_out,
   output logic      [2:0] fault_report_oe_n_out
);

   localparam logic [2:0] MINPW_LAST = 3'(`GDFM_MINPW_CYCLES - 1);
   localparam logic [3:0] BLANK_LOAD = 4'(`GDFM_BLANK_CYCLES);
   localparam logic [3:0] SSD_LOAD   = 4'(`GDFM_SSD_CYCLES);

   gdfm_pkg::gdfm_state_t st;
   gdfm_pkg::gdfm_state_t next_st;
   gdfm_pkg::gdfm_pins_t  pins;

   logic [2:0] prim_raw;
   logic [2:0] prim_st;
   logic [2:0] prim_trig;
   logic [5:0] raw_v;
   logic [5:0] eff_v;
   logic [5:0] rise_v;
   logic [5:0] desat_v;
   logic [5:0] sec_raw;
   logic [5:0] sec_st;
   logic [5:0] sec_trig;
   logic [5:0] fault_v;
   logic [5:0] next_gate;
   logic [8:0] lt_trig;
   logic [8:0] lt_active;

   // Counting down to zero, shared by blanking and soft-shutdown timers
   function automatic logic [3:0] dec_sat(input logic [3:0] v);
      dec_sat = (v == 4'h0) ? 4'h0 : v - 4'h1;
   endfunction : dec_sat

   always_comb begin
      pins.ls_cmd      = low_side_switch_cmd_in;
      pins.hs_cmd      = high_side_switch_cmd_in;
      pins.rst_n       = driver_reset_active_low_in;
      pins.per_phase   = report_per_phase_in;
      pins.prim_supply_undervoltage_lockout   = supply_undervoltage_lockout_in;
      pins.prim_pgood  = primary_power_good_in;
      pins.sec_supply_undervoltage_lockout    = sec_supply_undervoltage_lockout_in;
      pins.sec_pgood   = sec_power_good_in;
      pins.desat       = desat_comparator_in;
      pins.sec_present = sec_supply_present_in;
   end

   // Latch timers: 0..2 primary per phase, 3..8 secondary per side
   assign lt_trig = {sec_trig, prim_trig};

   for (genvar i = 0; i < 9; i++) begin : g_latch
      gdfm_latch_timer #(
         .CYCLES(LATCH_CYCLES)
      ) u_latch (
         .clk_sys_in(clk_sys_in),
         .reset_in  (reset_in),
         .trigger_in(lt_trig[i]),
         .active_out(lt_active[i])
      );
   end

   always_comb begin
      next_st   = st;
      prim_raw  = '0;
      prim_st   = '0;
      raw_v     = '0;
      eff_v     = '0;
      rise_v    = '0;
      desat_v   = '0;
      sec_raw   = '0;
      sec_st    = '0;
      fault_v   = '0;
      next_gate = '0;

      // Two-stage synchronisers; stage one is read only by stage two
      next_st.s1 = pins;
      next_st.s2 = st.s1;

      for (int p = 0; p < 3; p++) begin
         prim_raw[p] = st.s2.prim_supply_undervoltage_lockout[p] | ~st.s2.prim_pgood[p]
                     | ~(&st.s2.sec_present[2*p +: 2]);
         prim_st[p]  = prim_raw[p] | lt_active[p];
         // Reset pin zeroes commands before the spike filter
         raw_v[2*p]   = st.s2.ls_cmd[p] & st.s2.rst_n;
         raw_v[2*p+1] = st.s2.hs_cmd[p] & st.s2.rst_n;
      end
      prim_trig         = prim_raw & ~st.prev_prim;
      next_st.prev_prim = prim_raw;

      for (int s = 0; s < 6; s++) begin
         // Spike filter: a level must hold for the minimum width to pass
         if (raw_v[s] == st.filt[s]) begin
            next_st.fcnt[s] = 3'h0;
         end else if (st.fcnt[s] == MINPW_LAST) begin
            next_st.filt[s] = raw_v[s];
            next_st.fcnt[s] = 3'h0;
         end else begin
            next_st.fcnt[s] = st.fcnt[s] + 3'h1;
         end

         // Overlapping commands block both sides of the phase
         eff_v[s]  = st.filt[s] & ~st.filt[s ^ 1] & st.s2.rst_n;
         rise_v[s] = eff_v[s] & ~st.cmd_d[s];

         desat_v[s] = st.gate[s] & (st.blank[s] == 4'h0) & st.s2.desat[s];
         sec_raw[s] = st.s2.sec_supply_undervoltage_lockout[s] | ~st.s2.sec_pgood[s] | desat_v[s];
         sec_st[s]  = sec_raw[s] | lt_active[3 + s];
         fault_v[s] = sec_st[s] | prim_st[s >> 1];

         // Any fault disarms; only a fresh rising edge re-arms
         if (fault_v[s]) begin
            next_st.armed[s] = 1'b0;
         end else if (rise_v[s]) begin
            next_st.armed[s] = 1'b1;
         end
         next_gate[s] = ~fault_v[s] & eff_v[s] & (st.armed[s] | rise_v[s]);
         next_st.gate[s] = next_gate[s];

         if (next_gate[s] & ~st.gate[s]) begin
            next_st.blank[s] = BLANK_LOAD;
         end else begin
            next_st.blank[s] = dec_sat(st.blank[s]);
         end

         // Fault onset while on uses the slow discharge path
         if (fault_v[s] & ~st.prev_fault[s] & st.gate[s]) begin
            next_st.ssd[s] = SSD_LOAD;
         end else begin
            next_st.ssd[s] = dec_sat(st.ssd[s]);
         end
         next_st.ssd_on[s] = (next_st.ssd[s] != 4'h0);
         next_st.clamp[s] = ~next_gate[s] & (next_st.ssd[s] == 4'h0);
      end
      next_st.cmd_d      = eff_v;
      next_st.prev_fault = fault_v;
      sec_trig           = sec_raw & ~st.prev_sec;
      next_st.prev_sec   = sec_raw;

      for (int p = 0; p < 3; p++) begin
         next_st.conv_en[p]  = ~prim_st[p];
         next_st.bot_oe_n[p] = st.s2.per_phase | ~(sec_st[2*p] | prim_st[p]);
         next_st.top_oe_n[p] = st.s2.per_phase | ~(sec_st[2*p+1] | prim_st[p]);
         next_st.ph_oe_n[p]  = ~st.s2.per_phase
                             | ~(sec_st[2*p] | sec_st[2*p+1] | prim_st[p]);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         st          <= '0;
         st.bot_oe_n <= {3{`GDFM_RST_OE_N}};
         st.top_oe_n <= {3{`GDFM_RST_OE_N}};
         st.ph_oe_n  <= {3{`GDFM_RST_OE_N}};
         st.clamp    <= {6{`GDFM_RST_CLAMP}};
      end else begin
         st <= next_st;
      end
   end

   for (genvar p = 0; p < 3; p++) begin : g_out
      assign low_side_gate_drive_out[p]  = st.gate[2*p];
      assign high_side_gate_drive_out[p] = st.gate[2*p+1];
   end

   assign soft_shutdown_out            = st.ssd_on;
   assign miller_clamp_out             = st.clamp;
   assign converter_enable_out         = st.conv_en;
   assign bottom_fault_report_oe_n_out = st.bot_oe_n;
   assign top_fault_report_oe_n_out    = st.top_oe_n;
   assign fault_report_oe_n_out        = st.ph_oe_n;

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (reset_in);

   a_no_overlap: assert property (
      (st.gate[0] & st.gate[1]) == 1'b0 && (st.gate[2] & st.gate[3]) == 1'b0
      && (st.gate[4] & st.gate[5]) == 1'b0)
      else $error("both gates of a phase are on");

   a_reset_pin_off: assert property (
      !st.s2.rst_n |=> st.gate == 6'h00)
      else $error("gate on while driver reset is low");

   a_fault_gate_off: assert property (
      (st.gate & $past(fault_v)) == 6'h00)
      else $error("gate on one cycle after a fault");

   a_soft_shutdown: assert property (
      st.gate[0] && fault_v[0] && !st.prev_fault[0] |=> st.ssd[0] == SSD_LOAD && !st.gate[0])
      else $error("fault onset did not start soft shutdown");

   a_need_rise: assert property (
      !st.armed[0] && st.cmd_d[0] && eff_v[0] |=> !st.gate[0])
      else $error("gate resumed without a rising edge");

   a_desat_blank: assert property (
      $rose(st.gate[0]) |-> !desat_v[0] [*8])
      else $error("desaturation evaluated during blanking");

   a_prim_hold: assert property (
      prim_trig[1] |=> lt_active[1] [*8])
      else $error("primary latch not held");

   a_prim_report: assert property (
      prim_st[0] && !st.s2.per_phase |=> !st.bot_oe_n[0] && !st.top_oe_n[0] && !st.conv_en[0])
      else $error("primary fault not reported or converter on");

   a_side_report: assert property (
      !st.s2.per_phase && !sec_st[1] && !prim_st[0] && sec_st[0]
      |=> !st.bot_oe_n[0] && st.top_oe_n[0])
      else $error("per side report wrong");

   a_phase_report: assert property (
      st.s2.per_phase |=> st.bot_oe_n == 3'h7 && st.top_oe_n == 3'h7
      && st.ph_oe_n[2] == !$past(sec_st[4] | sec_st[5] | prim_st[2]))
      else $error("per phase report wrong");

   a_clamp_neg: assert property (
      st.clamp[3] == (!st.gate[3] && st.ssd[3] == 4'h0))
      else $error("miller clamp does not track negative drive");

   a_filter_width: assert property (
      $rose(st.filt[0]) |-> $past(raw_v[0], 1) && $past(raw_v[0], 5))
      else $error("short pulse passed the spike filter");

   c_gate_on: cover property ($rose(st.gate[0]));
   c_soft_stop: cover property ($rose(st.ssd[2] != 4'h0));
   c_prim_latch: cover property (prim_trig[0]);
   c_phase_report: cover property (st.s2.per_phase && !st.ph_oe_n[1]);

endmodule : gdfm_fault_manager

/* inc/gdfm_consts.svh */
// Timing counts, widths and reset values of the gate driver fault manager
`ifndef GDFM_CONSTS_SVH
`define GDFM_CONSTS_SVH

`define GDFM_CLK_PERIOD_NS  100
`define GDFM_LATCH_TIME_MS  14
`define GDFM_LATCH_CYCLES   ((`GDFM_LATCH_TIME_MS * 1000000) / `GDFM_CLK_PERIOD_NS)
`define GDFM_LATCH_W        18
`define GDFM_BLANK_TIME_NS  1050
`define GDFM_BLANK_CYCLES   ((`GDFM_BLANK_TIME_NS + `GDFM_CLK_PERIOD_NS - 1) / `GDFM_CLK_PERIOD_NS)
`define GDFM_BLANK_W        4
`define GDFM_MINPW_TIME_NS  500
`define GDFM_MINPW_CYCLES   ((`GDFM_MINPW_TIME_NS + `GDFM_CLK_PERIOD_NS - 1) / `GDFM_CLK_PERIOD_NS)
`define GDFM_FILT_W         3
`define GDFM_SSD_TIME_NS    1000
`define GDFM_SSD_CYCLES     ((`GDFM_SSD_TIME_NS + `GDFM_CLK_PERIOD_NS - 1) / `GDFM_CLK_PERIOD_NS)
`define GDFM_SSD_W          4
`define GDFM_RST_OE_N       1'b1
`define GDFM_RST_CLAMP      1'b1

`endif

/* inc/gdfm_pkg.sv */
// Types of the gate driver fault manager
package gdfm_pkg;

   // Pin inputs as seen after each synchroniser stage
   typedef struct packed {
      logic [2:0] ls_cmd;
      logic [2:0] hs_cmd;
      logic       rst_n;
      logic       per_phase;
      logic [2:0] prim_supply_undervoltage_lockout;
      logic [2:0] prim_pgood;
      logic [5:0] sec_supply_undervoltage_lockout;
      logic [5:0] sec_pgood;
      logic [5:0] desat;
      logic [5:0] sec_present;
   } gdfm_pins_t;

   // State of the supervisor apart from its latch timers; side index is 2*phase, +1 for high side
   typedef struct packed {
      gdfm_pins_t       s1;
      gdfm_pins_t       s2;
      logic [5:0]       filt;
      logic [5:0][2:0]  fcnt;
      logic [5:0]       cmd_d;
      logic [5:0]       armed;
      logic [5:0]       gate;
      logic [5:0]       prev_fault;
      logic [5:0]       prev_sec;
      logic [5:0][3:0]  blank;
      logic [5:0][3:0]  ssd;
      logic [5:0]       ssd_on;
      logic [5:0]       clamp;
      logic [2:0]       prev_prim;
      logic [2:0]       conv_en;
      logic [2:0]       bot_oe_n;
      logic [2:0]       top_oe_n;
      logic [2:0]       ph_oe_n;
   } gdfm_state_t;

   typedef struct packed {
      logic [17:0] count;
      logic        active;
   } gdfm_timer_t;

endpackage : gdfm_pkg

/* rtl/gdfm_latch_timer.sv */
// Fault latch timer: holds active for a fixed count after each trigger
`timescale 1ns/1ps
`include "gdfm_consts.svh"

module gdfm_latch_timer #(
   parameter int unsigned CYCLES = `GDFM_LATCH_CYCLES
) (
   // Clock and reset
   input  wire logic clk_sys_in,
   input  wire logic reset_in,
   // Control
   input  wire logic trigger_in,
   // Status
   output logic      active_out
);

   localparam logic [`GDFM_LATCH_W-1:0] LOAD = `GDFM_LATCH_W'(CYCLES);

   gdfm_pkg::gdfm_timer_t st;
   gdfm_pkg::gdfm_timer_t next_st;

   always_comb begin
      next_st = st;
      if (trigger_in) begin
         next_st.count = LOAD;
      end else if (st.count != '0) begin
         next_st.count = st.count - 1'b1;
      end
      next_st.active = (next_st.count != '0);
   end

   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign active_out = st.active;

endmodule : gdfm_latch_timer

/* bench/gdfm_ctrl_model.sv */
// Controller-side model: PWM and reset pins, fault pins with pull-ups
`timescale 1ns/1ps
module gdfm_ctrl_model (
   // Requests from the bench
   input  wire logic [2:0] ls_req_in,
   input  wire logic [2:0] hs_req_in,
   input  wire logic       rst_n_req_in,
   // Open-drain enables from the driver
   input  wire logic [2:0] bot_oe_n_in,
   input  wire logic [2:0] top_oe_n_in,
   input  wire logic [2:0] ph_oe_n_in,
   // Pins towards the driver
   output logic      [2:0] ls_cmd_out,
   output logic      [2:0] hs_cmd_out,
   output logic            rst_n_out,
   // Fault pin levels as the controller reads them
   output logic      [2:0] bot_level_out,
   output logic      [2:0] top_level_out,
   output logic      [2:0] ph_level_out
);
   assign ls_cmd_out = ls_req_in;
   assign hs_cmd_out = hs_req_in;
   assign rst_n_out  = rst_n_req_in;
   // A released pin reads high through the pull-up; unknown enables stay unknown
   assign bot_level_out = bot_oe_n_in;
   assign top_level_out = top_oe_n_in;
   assign ph_level_out  = ph_oe_n_in;
endmodule : gdfm_ctrl_model

/* bench/gdfm_fault_manager_tb.sv */
// Self-checking bench of the gate driver fault manager
`timescale 1ns/1ps
module gdfm_fault_manager_tb;
   localparam int LC = 50;
   typedef struct packed {
      logic       pp;
      logic [3:0] src;
      logic       bot;
      logic       top;
      logic       ph;
      logic       cv;
   } gdfm_row_t;
   logic       clk_sys_in = 1'h0;
   logic       reset_in   = 1'h1;
   logic       pp         = 1'h0;
   logic       driver_reset_active_low       = 1'h1;
   logic       rstp;
   logic [2:0] ls = 3'h1, hs = 3'h0, uv = 3'h0, pg = 3'h7;
   logic [2:0] lsp, hsp, lg, hg, cv, bo, to, po, bl, tl, pl;
   logic [5:0] suv = 6'h00, spg = 6'h3f, ds = 6'h00, sp = 6'h3f, ssd, clp;
   int         mismatches = 0;
   int         checks     = 0;
   int         cyc        = 0;
   int         i, k;
   // Sources: 1 prim supply_undervoltage_lockout, 2 prim pgood, 3 sec missing, 4/5 low supply_undervoltage_lockout/pgood, 6/7 high, 8 both
   gdfm_row_t  rows [13] = '{
      '{1'h0, 4'h0, 1'h1, 1'h1, 1'h1, 1'h1}, '{1'h0, 4'h1, 1'h0, 1'h0, 1'h0, 1'h0},
      '{1'h0, 4'h2, 1'h0, 1'h0, 1'h0, 1'h0}, '{1'h0, 4'h3, 1'h0, 1'h0, 1'h0, 1'h0},
      '{1'h0, 4'h4, 1'h0, 1'h1, 1'h0, 1'h1}, '{1'h0, 4'h5, 1'h0, 1'h1, 1'h0, 1'h1},
      '{1'h0, 4'h6, 1'h1, 1'h0, 1'h0, 1'h1}, '{1'h0, 4'h7, 1'h1, 1'h0, 1'h0, 1'h1},
      '{1'h0, 4'h8, 1'h0, 1'h0, 1'h0, 1'h1}, '{1'h1, 4'h0, 1'h1, 1'h1, 1'h1, 1'h1},
      '{1'h1, 4'h4, 1'h1, 1'h1, 1'h0, 1'h1}, '{1'h1, 4'h6, 1'h1, 1'h1, 1'h0, 1'h1},
      '{1'h1, 4'h1, 1'h1, 1'h1, 1'h0, 1'h0}};

   gdfm_ctrl_model M (.ls_req_in(ls), .hs_req_in(hs), .rst_n_req_in(driver_reset_active_low), .bot_oe_n_in(bo),
      .top_oe_n_in(to), .ph_oe_n_in(po), .ls_cmd_out(lsp), .hs_cmd_out(hsp), .rst_n_out(rstp),
      .bot_level_out(bl), .top_level_out(tl), .ph_level_out(pl));

   gdfm_fault_manager #(.LATCH_CYCLES(LC)) DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .low_side_switch_cmd_in(lsp), .high_side_switch_cmd_in(hsp),
      .driver_reset_active_low_in(rstp), .report_per_phase_in(pp),
      .supply_undervoltage_lockout_in(uv), .primary_power_good_in(pg),
      .sec_supply_undervoltage_lockout_in(suv), .sec_power_good_in(spg),
      .desat_comparator_in(ds), .sec_supply_present_in(sp), .low_side_gate_drive_out(lg),
      .high_side_gate_drive_out(hg), .soft_shutdown_out(ssd), .miller_clamp_out(clp),
      .converter_enable_out(cv), .bottom_fault_report_oe_n_out(bo),
      .top_fault_report_oe_n_out(to), .fault_report_oe_n_out(po));

   initial begin
      forever #50 clk_sys_in = ~clk_sys_in;
   end

   // Whole run is about 1350 cycles; the ceiling leaves ample margin
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         results();
      end
   end

   task tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #10;
   endtask : tick

   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task setf(input logic [3:0] s);
      uv  = 3'h0;
      pg  = 3'h7;
      suv = 6'h00;
      spg = 6'h3f;
      sp  = 6'h3f;
      case (s)
         4'h1: uv[0] = 1'h1;
         4'h2: pg[0] = 1'h0;
         4'h3: sp[0] = 1'h0;
         4'h4: suv[0] = 1'h1;
         4'h5: spg[0] = 1'h0;
         4'h6: suv[1] = 1'h1;
         4'h7: spg[1] = 1'h0;
         4'h8: suv[1:0] = 2'h3;
         default: ;
      endcase
   endtask : setf

   task results;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   initial begin
      tick(3);
      chk("reset outputs", {lg, hg, cv, bo, to}, 16'h003f);
      chk("reset clamp", {ssd, clp, po}, 16'h01ff);
      tick(2);
      reset_in = 1'h0;
      for (i = 0; i < LC + 20 && cv !== 3'h7; i++) tick(1);
      chk("conv after start", cv, 16'h0007);
      chk("gate waits edge", lg, 16'h0000);
      $display("test reset done");
      ls = 3'h0;
      tick(10);
      ls[0] = 1'h1;
      tick(6);
      chk("gate early", lg[0], 16'h0000);
      tick(3);
      chk("gate rise", lg[0], 16'h0001);
      chk("clamp off", clp[0], 16'h0000);
      ls[0] = 1'h0;
      tick(3);
      ls[0] = 1'h1;
      tick(12);
      chk("negative glitch", lg[0], 16'h0001);
      ls[0] = 1'h0;
      tick(6);
      chk("gate late fall", lg[0], 16'h0001);
      tick(3);
      chk("gate fall", {lg[0], clp[0]}, 16'h0001);
      hs[1] = 1'h1;
      tick(3);
      hs[1] = 1'h0;
      tick(12);
      chk("positive glitch", hg[1], 16'h0000);
      ls[2] = 1'h1;
      hs[2] = 1'h1;
      tick(12);
      chk("overlap", {lg[2], hg[2]}, 16'h0000);
      hs = 3'h0;
      ls = 3'h2;
      tick(12);
      chk("gate on", lg[1], 16'h0001);
      driver_reset_active_low = 1'h0;
      tick(4);
      chk("reset pin", {lg, hg}, 16'h0000);
      driver_reset_active_low = 1'h1;
      ls = 3'h0;
      tick(12);
      $display("test pwm path done");
      for (i = 0; i < 13; i++) begin
         pp = rows[i].pp;
         setf(rows[i].src);
         tick(5);
         if (!rows[i].pp) begin
            chk("bottom", bl, {2'h3, rows[i].bot});
            chk("top", tl, {2'h3, rows[i].top});
         end else begin
            chk("phase", pl, {2'h3, rows[i].ph});
         end
         chk("conv", cv, {2'h3, rows[i].cv});
         setf(4'h0);
         tick(LC + 12);
         chk("release", {bl, tl, pl}, 16'h01ff);
      end
      pp = 1'h0;
      $display("test fault table done");
      for (k = 0; k < 2; k++) begin
         ls[0] = 1'h1;
         tick(10);
         if (k == 0) begin
            ds[0] = 1'h1;
            tick(4);
            ds[0] = 1'h0;
            tick(4);
            chk("blanking", {lg[0], bl[0]}, 16'h0003);
            tick(12);
            ds[0] = 1'h1;
         end else begin
            suv[0] = 1'h1;
         end
         tick(4);
         chk("fault gate", lg[0], 16'h0000);
         chk("soft shutdown", ssd[0], 16'h0001);
         chk("fault pin", bl, 16'h0006);
         tick(12);
         chk("ssd end", {ssd[0], clp[0]}, 16'h0001);
         ds = 6'h00;
         suv = 6'h00;
         tick(LC - 25);
         chk("latched", {bl, lg[0]}, 16'h000c);
         tick(20);
         chk("released", {bl, lg[0]}, 16'h000e);
         ls[0] = 1'h0;
         tick(6);
         ls[0] = 1'h1;
         tick(9);
         chk("resume", lg[0], 16'h0001);
         ls[0] = 1'h0;
         tick(12);
      end
      $display("test gate faults done");
      hs[1] = 1'h1;
      tick(10);
      uv[1] = 1'h1;
      tick(4);
      chk("prim gate", {hg[1], bl[1], tl[1]}, 16'h0000);
      chk("prim soft shutdown", ssd[3], 16'h0001);
      chk("prim conv", cv, 16'h0005);
      tick(LC + 20);
      chk("prim held", {bl[1], cv[1]}, 16'h0000);
      uv[1] = 1'h0;
      tick(12);
      chk("prim clear", {cv[1], hg[1]}, 16'h0002);
      hs[1] = 1'h0;
      tick(6);
      hs[1] = 1'h1;
      tick(9);
      chk("prim resume", hg[1], 16'h0001);
      $display("test primary fault done");
      results();
   end
endmodule : gdfm_fault_manager_tb
